// ===== include/cae_regs.svh
// Constants of the arithmetic and flow execution block.
`ifndef CAE_REGS_SVH
`define CAE_REGS_SVH

// ***************************************************************
// Status flag positions and reset value.
// ***************************************************************
`define CAE_FLAG_C 3'h0
`define CAE_FLAG_Z 3'h1
`define CAE_FLAG_N 3'h2
`define CAE_FLAG_V 3'h3
`define CAE_FLAG_S 3'h4
`define CAE_FLAG_H 3'h5
`define CAE_FLAG_I 3'h7
`define CAE_SREG_RST 8'h00
`define CAE_LOGIC_KEEP 8'hF1

// ***************************************************************
// Register indices.
// ***************************************************************
`define CAE_ZLO_IDX 5'h1E
`define CAE_ZHI_IDX 5'h1F
`define CAE_PROD_LO_IDX 5'h00
`define CAE_PROD_HI_IDX 5'h01
`define CAE_REG_RST 8'h00

// ***************************************************************
// Cycle counts per instruction.
// ***************************************************************
`define CAE_CYC_BYTE 3'h1
`define CAE_CYC_WORD 3'h2
`define CAE_CYC_FMUL 3'h2
`define CAE_CYC_PJMP 3'h2
`define CAE_CYC_PCALL 3'h3
`define CAE_CYC_CALL 3'h4
`define CAE_CYC_RET 3'h4
`define CAE_POP_CNT 3'h2

`endif

// ===== include/cae_pkg.sv
// Types of the arithmetic and flow execution block.
package cae_pkg;

    typedef enum logic [4:0] {
        add_carry_op = 5'h00,
        word_add_immediate_op = 5'h01,
        subtract_reg_op = 5'h02,
        subtract_borrow_reg_op = 5'h03,
        subtract_const_op = 5'h04,
        subtract_borrow_const_op = 5'h05,
        word_subtract_immediate_op = 5'h06,
        bitwise_and_reg_op = 5'h07,
        bitwise_and_const_op = 5'h08,
        bitwise_or_const_op = 5'h09,
        frac_mult_signed_unsigned_op = 5'h0A,
        pointer_jump_op = 5'h0B,
        pointer_call_op = 5'h0C,
        direct_call_op = 5'h0D,
        subroutine_return_op = 5'h0E,
        interrupt_return_op = 5'h0F,
        compare_const_op = 5'h10,
        compare_borrow_op = 5'h11
    } cae_op_t;

    typedef enum logic [1:0] {
        st_idle = 2'h1,
        st_busy = 2'h2
    } cae_state_t;

    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic lo_en;
        logic hi_en;
        logic [4:0] lo_idx;
        logic [4:0] hi_idx;
        logic [7:0] sreg;
        logic [15:0] pc;
        logic pc_ld;
        logic push;
        logic pop;
    } cae_res_t;

endpackage

// ===== include/cae_dp_if.sv
// Datapath signals between the sequencer and its arithmetic units.
`timescale 1ns/10ps
`default_nettype none
interface cae_dp_if;
    logic [7:0] a;
    logic [7:0] b;
    logic cin;
    logic sub;
    logic [7:0] res;
    logic c;
    logic z;
    logic n;
    logic v;
    logic h;
    logic [7:0] ma;
    logic [7:0] mb;
    logic [15:0] prod;

    modport alu_mp (input a, b, cin, sub, output res, c, z, n, v, h);
    modport mul_mp (input ma, mb, output prod);
    modport core_mp (output a, b, cin, sub, ma, mb,
        input res, c, z, n, v, h, prod);
endinterface
`default_nettype wire

// ===== verilog/cae_alu8.sv
// Eight-bit adder and subtractor with status flags.
`timescale 1ns/10ps
`default_nettype none
module cae_alu8 (
    cae_dp_if.alu_mp dp
);
    logic [8:0] sum;
    logic [4:0] nib;

    always_comb begin
        if (dp.sub) begin
            sum = {1'b0, dp.a} - {1'b0, dp.b} - {8'h00, dp.cin};
            nib = {1'b0, dp.a[3:0]} - {1'b0, dp.b[3:0]} - {4'h0, dp.cin};
            dp.v = (dp.a[7] & ~dp.b[7] & ~sum[7])
                | (~dp.a[7] & dp.b[7] & sum[7]);
        end else begin
            sum = {1'b0, dp.a} + {1'b0, dp.b} + {8'h00, dp.cin};
            nib = {1'b0, dp.a[3:0]} + {1'b0, dp.b[3:0]} + {4'h0, dp.cin};
            dp.v = (dp.a[7] & dp.b[7] & ~sum[7])
                | (~dp.a[7] & ~dp.b[7] & sum[7]);
        end
        dp.res = sum[7:0];
        dp.c = sum[8];
        dp.h = nib[4];
        dp.n = sum[7];
        dp.z = (sum[7:0] == 8'h00);
    end
endmodule
`default_nettype wire

// ===== verilog/cae_fmul.sv
// Signed by unsigned eight-bit multiplier.
`timescale 1ns/10ps
`default_nettype none
module cae_fmul (
    cae_dp_if.mul_mp dp
);
    logic signed [17:0] full;

    always_comb begin
        full = $signed({dp.ma[7], dp.ma}) * $signed({1'b0, dp.mb});
        dp.prod = full[15:0];
    end
endmodule
`default_nettype wire

// ===== verilog/cae_exec.sv
// Sequencer that executes arithmetic, multiply and flow instructions.
`timescale 1ns/10ps
`include "cae_regs.svh"
`default_nettype none
module cae_exec
    import cae_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire cae_op_t op_i,
    input wire logic [4:0] dst_idx_i,
    input wire logic [4:0] src_idx_i,
    input wire logic [7:0] imm_i,
    input wire logic [15:0] target_i,
    input wire logic [15:0] next_pc_i,
    input wire logic [15:0] stack_data_i,
    input wire logic reg_wr_en_i,
    input wire logic [4:0] reg_wr_idx_i,
    input wire logic [7:0] reg_wr_data_i,
    input wire logic sreg_wr_en_i,
    input wire logic [7:0] sreg_wr_data_i,
    input wire logic [4:0] reg_rd_idx_i,
    output logic ready_o,
    output logic done_o,
    output logic [15:0] pc_o,
    output logic pc_load_o,
    output logic stack_push_o,
    output logic stack_pop_o,
    output logic [15:0] stack_data_o,
    output logic [7:0] sreg_o,
    output logic [7:0] reg_rd_data_o
);
    // ***************************************************************
    // Declarations and arithmetic units.
    // ***************************************************************
    logic [7:0] rf_q [0:31];
    logic [7:0] rf_next [0:31];
    cae_state_t state_reg, state_next;
    logic [2:0] cnt_reg, cnt_next;
    cae_res_t pend_reg, pend_next, res, cmt;
    logic [2:0] cyc;
    logic commit;
    logic acc;
    logic [7:0] rd_v, rr_v, zhi_v;
    logic c_v;
    logic [4:0] hi_idx;
    logic [15:0] word_v, k16, wres, zptr, fres;
    logic wv, wc;
    logic done_next, pc_load_next, push_next, pop_next;
    logic [15:0] pc_next, push_data_next;
    logic [7:0] sreg_next, rd_data_next;

    cae_dp_if dp ();
    cae_alu8 u_alu (.dp(dp.alu_mp));
    cae_fmul u_mul (.dp(dp.mul_mp));

    // ***************************************************************
    // Operand fetch and result computation.
    // ***************************************************************
    always_comb begin
        rd_v = rf_q[dst_idx_i];
        rr_v = rf_q[src_idx_i];
        c_v = sreg_o[`CAE_FLAG_C];
        hi_idx = {dst_idx_i[4:1], 1'b1};
        word_v = {rf_q[hi_idx], rf_q[{dst_idx_i[4:1], 1'b0}]};
        k16 = {10'h000, imm_i[5:0]};
        zhi_v = rf_q[`CAE_ZHI_IDX];
        zptr = {zhi_v, rf_q[`CAE_ZLO_IDX]};
        dp.a = rd_v;
        dp.b = rr_v;
        dp.cin = 1'b0;
        dp.sub = 1'b1;
        dp.ma = rd_v;
        dp.mb = rr_v;
        case (op_i)
            add_carry_op: begin
                dp.cin = c_v;
                dp.sub = 1'b0;
            end
            subtract_borrow_reg_op, compare_borrow_op: begin
                dp.cin = c_v;
            end
            subtract_const_op, compare_const_op: begin
                dp.b = imm_i;
            end
            subtract_borrow_const_op: begin
                dp.b = imm_i;
                dp.cin = c_v;
            end
            default: begin
                dp.cin = 1'b0;
            end
        endcase
        if (op_i == word_add_immediate_op) begin
            wres = word_v + k16;
            wv = ~word_v[15] & wres[15];
            wc = ~wres[15] & word_v[15];
        end else begin
            wres = word_v - k16;
            wv = word_v[15] & ~wres[15];
            wc = wres[15] & ~word_v[15];
        end
        fres = {dp.prod[14:0], 1'b0};
    end

    always_comb begin
        res = '0;
        res.sreg = sreg_o;
        res.lo_idx = dst_idx_i;
        res.hi_idx = hi_idx;
        res.lo = dp.res;
        res.pc = zptr;
        cyc = `CAE_CYC_BYTE;
        case (op_i)
            add_carry_op, subtract_reg_op, subtract_borrow_reg_op,
            subtract_const_op, subtract_borrow_const_op,
            compare_const_op, compare_borrow_op: begin
                res.lo_en = (op_i != compare_const_op)
                    && (op_i != compare_borrow_op);
                res.sreg[`CAE_FLAG_C] = dp.c;
                res.sreg[`CAE_FLAG_Z] = dp.z;
                res.sreg[`CAE_FLAG_N] = dp.n;
                res.sreg[`CAE_FLAG_V] = dp.v;
                res.sreg[`CAE_FLAG_H] = dp.h;
            end
            word_add_immediate_op, word_subtract_immediate_op: begin
                res.lo = wres[7:0];
                res.hi = wres[15:8];
                res.lo_idx = {dst_idx_i[4:1], 1'b0};
                res.lo_en = 1'b1;
                res.hi_en = 1'b1;
                res.sreg[`CAE_FLAG_C] = wc;
                res.sreg[`CAE_FLAG_Z] = (wres == 16'h0000);
                res.sreg[`CAE_FLAG_N] = wres[15];
                res.sreg[`CAE_FLAG_V] = wv;
                res.sreg[`CAE_FLAG_S] = wres[15] ^ wv;
                cyc = `CAE_CYC_WORD;
            end
            bitwise_and_reg_op, bitwise_and_const_op,
            bitwise_or_const_op: begin
                if (op_i == bitwise_and_reg_op) begin
                    res.lo = rd_v & rr_v;
                end else if (op_i == bitwise_and_const_op) begin
                    res.lo = rd_v & imm_i;
                end else begin
                    res.lo = rd_v | imm_i;
                end
                res.lo_en = 1'b1;
                res.sreg[`CAE_FLAG_Z] = (res.lo == 8'h00);
                res.sreg[`CAE_FLAG_N] = res.lo[7];
                res.sreg[`CAE_FLAG_V] = 1'b0;
            end
            frac_mult_signed_unsigned_op: begin
                res.lo = fres[7:0];
                res.hi = fres[15:8];
                res.lo_idx = `CAE_PROD_LO_IDX;
                res.hi_idx = `CAE_PROD_HI_IDX;
                res.lo_en = 1'b1;
                res.hi_en = 1'b1;
                res.sreg[`CAE_FLAG_C] = dp.prod[15];
                res.sreg[`CAE_FLAG_Z] = (fres == 16'h0000);
                cyc = `CAE_CYC_FMUL;
            end
            pointer_jump_op: begin
                res.pc_ld = 1'b1;
                cyc = `CAE_CYC_PJMP;
            end
            pointer_call_op: begin
                res.pc_ld = 1'b1;
                res.push = 1'b1;
                cyc = `CAE_CYC_PCALL;
            end
            direct_call_op: begin
                res.pc = target_i;
                res.pc_ld = 1'b1;
                res.push = 1'b1;
                cyc = `CAE_CYC_CALL;
            end
            subroutine_return_op, interrupt_return_op: begin
                res.pc_ld = 1'b1;
                res.pop = 1'b1;
                if (op_i == interrupt_return_op) begin
                    res.sreg[`CAE_FLAG_I] = 1'b1;
                end
                cyc = `CAE_CYC_RET;
            end
            default: begin
                cyc = `CAE_CYC_BYTE;
            end
        endcase
    end

    // ***************************************************************
    // Sequencer.
    // ***************************************************************
    assign ready_o = (state_reg == st_idle);
    assign acc = start_i && ready_o;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        pend_next = pend_reg;
        commit = 1'b0;
        cmt = pend_reg;
        case (state_reg)
            st_idle: begin
                cmt = res;
                if (start_i) begin
                    pend_next = res;
                    if (cyc == `CAE_CYC_BYTE) begin
                        commit = 1'b1;
                    end else begin
                        state_next = st_busy;
                        cnt_next = cyc - 3'h1;
                    end
                end
            end
            st_busy: begin
                cnt_next = cnt_reg - 3'h1;
                if (pend_reg.pop && cnt_reg == `CAE_POP_CNT) begin
                    pend_next.pc = stack_data_i;
                end
                if (cnt_reg == 3'h1) begin
                    commit = 1'b1;
                    state_next = st_idle;
                end
            end
            default: begin
                state_next = st_idle;
            end
        endcase
    end

    // ***************************************************************
    // Register file, status and outputs.
    // ***************************************************************
    always_comb begin
        rf_next = rf_q;
        sreg_next = sreg_o;
        if (commit) begin
            if (cmt.lo_en) begin
                rf_next[cmt.lo_idx] = cmt.lo;
            end
            if (cmt.hi_en) begin
                rf_next[cmt.hi_idx] = cmt.hi;
            end
            sreg_next = cmt.sreg;
        end else if (ready_o) begin
            if (reg_wr_en_i) begin
                rf_next[reg_wr_idx_i] = reg_wr_data_i;
            end
            if (sreg_wr_en_i) begin
                sreg_next = sreg_wr_data_i;
            end
        end
        done_next = commit;
        pc_load_next = commit && cmt.pc_ld;
        pc_next = pc_load_next ? cmt.pc : pc_o;
        push_next = commit && cmt.push;
        push_data_next = (acc && res.push) ? next_pc_i : stack_data_o;
        pop_next = acc && res.pop;
        rd_data_next = rf_q[reg_rd_idx_i];
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 32; i++) begin
                rf_q[i] <= `CAE_REG_RST;
            end
            state_reg <= st_idle;
            cnt_reg <= 3'h0;
            pend_reg <= '0;
            sreg_o <= `CAE_SREG_RST;
            done_o <= 1'b0;
            pc_o <= 16'h0000;
            pc_load_o <= 1'b0;
            stack_push_o <= 1'b0;
            stack_pop_o <= 1'b0;
            stack_data_o <= 16'h0000;
            reg_rd_data_o <= 8'h00;
        end else begin
            rf_q <= rf_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            pend_reg <= pend_next;
            sreg_o <= sreg_next;
            done_o <= done_next;
            pc_o <= pc_next;
            pc_load_o <= pc_load_next;
            stack_push_o <= push_next;
            stack_pop_o <= pop_next;
            stack_data_o <= push_data_next;
            reg_rd_data_o <= rd_data_next;
        end
    end

    // ***************************************************************
    // Assertions.
    // ***************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_two;
        !done_o ##1 done_o;
    endsequence
    sequence s_four;
        !done_o [*3] ##1 done_o;
    endsequence

    adc_sum_a: assert property (acc && op_i == add_carry_op |=> done_o
        && rf_q[$past(dst_idx_i)] == 8'($past(rd_v) + $past(rr_v)
        + {7'h00, $past(c_v)})) else $error("add with carry wrong");
    wadd_pair_a: assert property (acc && op_i == word_add_immediate_op
        |=> s_two ##0 {rf_q[$past(hi_idx, 2)], rf_q[$past(hi_idx, 2) - 5'h01]}
        == $past(word_v, 2) + {10'h000, $past(imm_i[5:0], 2)})
        else $error("word add wrong");
    sub_borrow_a: assert property (acc && op_i == subtract_borrow_reg_op
        |=> rf_q[$past(dst_idx_i)] == 8'($past(rd_v) - $past(rr_v)
        - {7'h00, $past(c_v)})) else $error("register subtract wrong");
    subc_value_a: assert property (acc && op_i == subtract_const_op
        |=> done_o && rf_q[$past(dst_idx_i)] == 8'($past(rd_v) - $past(imm_i)))
        else $error("constant subtract wrong");
    subcb_value_a: assert property (acc && op_i == subtract_borrow_const_op
        |=> rf_q[$past(dst_idx_i)] == 8'($past(rd_v) - $past(imm_i)
        - {7'h00, $past(c_v)})) else $error("constant borrow wrong");
    wsub_sign_a: assert property (acc && op_i == word_subtract_immediate_op
        |=> s_two ##0 sreg_o[`CAE_FLAG_S] == ($signed($past(word_v, 2))
        < $signed({10'h000, $past(imm_i[5:0], 2)}))
        && {rf_q[$past(hi_idx, 2)], rf_q[$past(hi_idx, 2) - 5'h01]}
        == $past(word_v, 2) - {10'h000, $past(imm_i[5:0], 2)})
        else $error("word subtract wrong");
    and_flags_a: assert property (acc && op_i == bitwise_and_reg_op
        |=> !sreg_o[`CAE_FLAG_V] && (sreg_o & `CAE_LOGIC_KEEP)
        == ($past(sreg_o) & `CAE_LOGIC_KEEP)) else $error("and flags wrong");
    or_value_a: assert property (acc && op_i == bitwise_or_const_op
        |=> rf_q[$past(dst_idx_i)] == ($past(rd_v) | $past(imm_i))
        && sreg_o[`CAE_FLAG_C] == $past(c_v)) else $error("or wrong");
    fmul_pair_a: assert property (acc && op_i == frac_mult_signed_unsigned_op
        |=> s_two ##0 {rf_q[1], rf_q[0]} == 16'(({{8{$past(rd_v[7], 2)}},
        $past(rd_v, 2)} * {8'h00, $past(rr_v, 2)}) << 1))
        else $error("fractional product wrong");
    pjmp_load_a: assert property (acc && op_i == pointer_jump_op
        |=> !pc_load_o ##1 pc_load_o && pc_o == $past(zptr, 2)
        && sreg_o == $past(sreg_o, 2)) else $error("pointer jump wrong");
    pcall_push_a: assert property (acc && op_i == pointer_call_op
        |=> !pc_load_o [*2] ##1 pc_load_o && stack_push_o
        && stack_data_o == $past(next_pc_i, 3)) else $error("pointer call wrong");
    call_target_a: assert property (acc && op_i == direct_call_op
        |=> s_four ##0 pc_load_o && stack_push_o
        && pc_o == $past(target_i, 4)) else $error("direct call wrong");
    ret_pop_a: assert property (acc && op_i == subroutine_return_op
        |=> stack_pop_o ##1 !pc_load_o ##1 !pc_load_o ##1 pc_load_o
        && sreg_o == $past(sreg_o, 4)) else $error("return wrong");
    interrupt_return_op_enable_a: assert property (acc && op_i == interrupt_return_op
        |=> s_four ##0 sreg_o[`CAE_FLAG_I]) else $error("interrupt return wrong");
    cpi_nowrite_a: assert property (acc && op_i == compare_const_op
        |=> rf_q[$past(dst_idx_i)] == $past(rd_v)
        && sreg_o[`CAE_FLAG_Z] == ($past(rd_v) == $past(imm_i)))
        else $error("compare constant wrong");
    cpc_nowrite_a: assert property (acc && op_i == compare_borrow_op
        |=> rf_q[$past(dst_idx_i)] == $past(rd_v) && sreg_o[`CAE_FLAG_Z]
        == ($past(rd_v) == 8'($past(rr_v) + {7'h00, $past(c_v)})))
        else $error("compare borrow wrong");
    zptr_high_a: assert property (acc && op_i == pointer_jump_op
        |=> ##1 pc_o[15:8] == $past(zhi_v, 2)) else $error("pointer order wrong");
endmodule
`default_nettype wire

// ===== bench/test_cpu_arith_flow_instr_exec.sv
// Self-checking testbench of the arithmetic and flow execution block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    n_errors++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module test_cpu_arith_flow_instr_exec
    import cae_pkg::*;
;
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0, start_i = 1'b0;
    cae_op_t op_i = add_carry_op;
    logic [4:0] dst_idx_i = 5'h00, src_idx_i = 5'h00, reg_wr_idx_i = 5'h00;
    logic [4:0] reg_rd_idx_i = 5'h00;
    logic [7:0] imm_i = 8'h00, reg_wr_data_i = 8'h00, sreg_wr_data_i = 8'h00;
    logic [15:0] target_i = 16'h0000, next_pc_i = 16'h0000;
    logic [15:0] stack_data_i = 16'h0000;
    logic reg_wr_en_i = 1'b0, sreg_wr_en_i = 1'b0;
    logic ready_o, done_o, pc_load_o, stack_push_o, stack_pop_o;
    logic [15:0] pc_o, stack_data_o;
    logic [7:0] sreg_o, reg_rd_data_o, v;
    logic [15:0] sd;
    int n_errors = 0, checks_done = 0, cyc = 0, n, pop_at;
    cae_exec dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .start_i(start_i), .op_i(op_i), .dst_idx_i(dst_idx_i),
        .src_idx_i(src_idx_i), .imm_i(imm_i), .target_i(target_i),
        .next_pc_i(next_pc_i), .stack_data_i(stack_data_i),
        .reg_wr_en_i(reg_wr_en_i), .reg_wr_idx_i(reg_wr_idx_i),
        .reg_wr_data_i(reg_wr_data_i), .sreg_wr_en_i(sreg_wr_en_i),
        .sreg_wr_data_i(sreg_wr_data_i), .reg_rd_idx_i(reg_rd_idx_i),
        .ready_o(ready_o), .done_o(done_o), .pc_o(pc_o),
        .pc_load_o(pc_load_o), .stack_push_o(stack_push_o),
        .stack_pop_o(stack_pop_o), .stack_data_o(stack_data_o),
        .sreg_o(sreg_o), .reg_rd_data_o(reg_rd_data_o));
    always #12.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [4:0] i, input logic [7:0] d);
        @(negedge sys_clk_i);
        reg_wr_en_i = 1'b1; reg_wr_idx_i = i; reg_wr_data_i = d;
        @(negedge sys_clk_i);
        reg_wr_en_i = 1'b0;
    endtask
    task automatic wsr(input logic [7:0] d);
        @(negedge sys_clk_i);
        sreg_wr_en_i = 1'b1; sreg_wr_data_i = d;
        @(negedge sys_clk_i);
        sreg_wr_en_i = 1'b0;
    endtask
    task automatic rd(input logic [4:0] i);
        @(negedge sys_clk_i);
        reg_rd_idx_i = i;
        @(negedge sys_clk_i);
        v = reg_rd_data_o;
    endtask
    // Issues one instruction and counts cycles up to its done pulse.
    task automatic run(input cae_op_t o, input logic [4:0] d, s,
            input logic [7:0] k);
        @(negedge sys_clk_i);
        start_i = 1'b1; op_i = o; dst_idx_i = d; src_idx_i = s; imm_i = k;
        stack_data_i = ~sd;
        @(negedge sys_clk_i);
        start_i = 1'b0; n = 1; pop_at = 0;
        while (done_o !== 1'b1 && n < 10) begin
            if (stack_pop_o === 1'b1) pop_at = n;
            stack_data_i = (n == 2) ? sd : ~sd;
            @(negedge sys_clk_i);
            n++;
        end
    endtask
    task automatic t_adc();
        wr(5'h02, 8'hFF); wr(5'h03, 8'h00); wsr(8'h81);
        run(add_carry_op, 5'h02, 5'h03, 8'h00);
        `CHK("cycles", 1, n)
        `CHK("sreg", 8'hA3, sreg_o)
        rd(5'h02); `CHK("sum", 8'h00, v)
        $display("test adc done");
    endtask
    task automatic t_sub();
        wr(5'h04, 8'h10); wr(5'h05, 8'h20); wsr(8'h00);
        run(subtract_reg_op, 5'h04, 5'h05, 8'h00);
        `CHK("cycles", 1, n)
        `CHK("sreg", 8'h05, sreg_o)
        rd(5'h04); `CHK("diff", 8'hF0, v)
        wr(5'h06, 8'h50); wr(5'h07, 8'h10); wsr(8'h01);
        run(subtract_borrow_reg_op, 5'h06, 5'h07, 8'h00);
        `CHK("sreg", 8'h20, sreg_o)
        rd(5'h06); `CHK("diff", 8'h3F, v)
        wr(5'h10, 8'h80); wsr(8'h00);
        run(subtract_const_op, 5'h10, 5'h00, 8'h01);
        `CHK("cycles", 1, n)
        `CHK("sreg", 8'h28, sreg_o)
        rd(5'h10); `CHK("diff", 8'h7F, v)
        wr(5'h11, 8'h00); wsr(8'h01);
        run(subtract_borrow_const_op, 5'h11, 5'h00, 8'h00);
        `CHK("cycles", 1, n)
        `CHK("sreg", 8'h25, sreg_o)
        rd(5'h11); `CHK("diff", 8'hFF, v)
        $display("test subtract done");
    endtask
    task automatic t_word();
        wr(5'h18, 8'hFF); wr(5'h19, 8'hFF); wsr(8'h00);
        run(word_add_immediate_op, 5'h18, 5'h00, 8'hC1);
        `CHK("cycles", 2, n)
        `CHK("sreg", 8'h03, sreg_o)
        rd(5'h19); `CHK("hi", 8'h00, v)
        wr(5'h1A, 8'h00); wr(5'h1B, 8'h80); wsr(8'h00);
        run(word_subtract_immediate_op, 5'h1B, 5'h00, 8'h01);
        `CHK("cycles", 2, n)
        `CHK("sreg", 8'h18, sreg_o)
        rd(5'h1A); `CHK("lo", 8'hFF, v)
        rd(5'h1B); `CHK("hi", 8'h7F, v)
        $display("test word done");
    endtask
    task automatic t_logic();
        wr(5'h08, 8'hF0); wr(5'h09, 8'h3C); wsr(8'h3F);
        run(bitwise_and_reg_op, 5'h08, 5'h09, 8'h00);
        `CHK("cycles", 1, n)
        `CHK("sreg", 8'h31, sreg_o)
        run(bitwise_and_const_op, 5'h08, 5'h00, 8'h0F);
        `CHK("sreg", 8'h33, sreg_o)
        run(bitwise_or_const_op, 5'h08, 5'h00, 8'h80);
        `CHK("sreg", 8'h35, sreg_o)
        rd(5'h08); `CHK("or", 8'h80, v)
        $display("test logic done");
    endtask
    task automatic t_mul_cmp();
        wr(5'h10, 8'hC0); wr(5'h11, 8'h80); wsr(8'h00);
        run(frac_mult_signed_unsigned_op, 5'h10, 5'h11, 8'h00);
        `CHK("cycles", 2, n)
        `CHK("sreg", 8'h01, sreg_o)
        rd(5'h01); `CHK("prod hi", 8'hC0, v)
        rd(5'h00); `CHK("prod lo", 8'h00, v)
        wr(5'h10, 8'h05);
        run(compare_const_op, 5'h10, 5'h00, 8'h05);
        `CHK("sreg", 8'h02, sreg_o)
        rd(5'h10); `CHK("kept", 8'h05, v)
        wr(5'h12, 8'h00); wr(5'h13, 8'h00); wsr(8'h01);
        run(compare_borrow_op, 5'h12, 5'h13, 8'h00);
        `CHK("sreg", 8'h25, sreg_o)
        rd(5'h12); `CHK("kept", 8'h00, v)
        $display("test multiply compare done");
    endtask
    task automatic t_flow();
        wr(5'h1F, 8'h12); wr(5'h1E, 8'h34); wsr(8'h2A);
        next_pc_i = 16'h0456; target_i = 16'h7ABC; sd = 16'h0F0E;
        run(pointer_jump_op, 5'h00, 5'h00, 8'h00);
        `CHK("cycles", 2, n)
        `CHK("pc", 16'h1234, pc_o)
        `CHK("load", 1'b1, pc_load_o)
        run(pointer_call_op, 5'h00, 5'h00, 8'h00);
        `CHK("cycles", 3, n)
        `CHK("push", 1'b1, stack_push_o)
        `CHK("ret addr", 16'h0456, stack_data_o)
        `CHK("pc", 16'h1234, pc_o)
        run(direct_call_op, 5'h00, 5'h00, 8'h00);
        `CHK("cycles", 4, n)
        `CHK("push", 1'b1, stack_push_o)
        `CHK("pc", 16'h7ABC, pc_o)
        run(subroutine_return_op, 5'h00, 5'h00, 8'h00);
        `CHK("cycles", 4, n)
        `CHK("pop", 1, pop_at)
        `CHK("pc", 16'h0F0E, pc_o)
        `CHK("sreg", 8'h2A, sreg_o)
        sd = 16'h1357;
        run(interrupt_return_op, 5'h00, 5'h00, 8'h00);
        `CHK("cycles", 4, n)
        `CHK("pc", 16'h1357, pc_o)
        `CHK("sreg", 8'hAA, sreg_o)
        $display("test flow done");
    endtask
    initial begin
        sd = 16'h0000;
        repeat (12) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        `CHK("ready", 1'b1, ready_o)
        `CHK("sreg", 8'h00, sreg_o)
        t_adc();
        t_sub();
        t_word();
        t_logic();
        t_mul_cmp();
        t_flow();
        complete_run();
    end
endmodule
`default_nettype wire
